// [hw/jmi_cfg.svh]
/*
  Constants of the joystick measurement, interrupt and control block:
  register offsets, control field positions, reset values and timing counts.
  Assumes a 100 MHz system clock; included by bare name.
*/
`ifndef JMI_CFG_SVH
`define JMI_CFG_SVH

// register offsets on the serial address pointer
`define JMI_OFS_CTRL       8'h0F
`define JMI_OFS_X          8'h10
`define JMI_OFS_Y          8'h11
`define JMI_OFS_LEFT       8'h12
`define JMI_OFS_RIGHT      8'h13
`define JMI_OFS_TOP        8'h14
`define JMI_OFS_BOTTOM     8'h15

// control register fields
`define JMI_BIT_MODE       7
`define JMI_BIT_TB_HI      6
`define JMI_BIT_TB_LO      4
`define JMI_BIT_IRQ_OFF    3
`define JMI_BIT_ZONE       2
`define JMI_BIT_SRST       1
`define JMI_BIT_VALID      0

// reset values
`define JMI_RST_CTRL       8'hF0
`define JMI_RST_LEFT       8'h05
`define JMI_RST_RIGHT      8'hFB
`define JMI_RST_TOP        8'h05
`define JMI_RST_BOTTOM     8'hFB
`define JMI_RST_COORD      8'h00

// timing
`define JMI_CLK_MHZ        100
`define JMI_CYC_PER_MS     (`JMI_CLK_MHZ * 1000)
`define JMI_IRQ_DLY_US     450
`define JMI_IRQ_DLY_CYC    (`JMI_IRQ_DLY_US * `JMI_CLK_MHZ)
`define JMI_SRST_CYC       8'h04

// wake-up periods in ms, codes 000b..111b
`define JMI_TB0_MS         20
`define JMI_TB1_MS         40
`define JMI_TB2_MS         80
`define JMI_TB3_MS         100
`define JMI_TB4_MS         140
`define JMI_TB5_MS         200
`define JMI_TB6_MS         260
`define JMI_TB7_MS         320

`endif

// [hw/jmi_pkg.sv]
/*
  Types of the joystick measurement, interrupt and control block.
  Assumes nothing of its surroundings.
*/
package jmi_pkg;

  typedef enum logic [2:0]
  {
    ST_RUN  = 3'b001,
    ST_MEAS = 3'b010,
    ST_SRST = 3'b100
  } jmi_state_t;

endpackage : jmi_pkg

// [hw/jmi_pulse_sync.sv]
/*
  Carries a one-cycle event from one clock domain to another by a toggle.
  Assumes source events are spaced by at least three destination cycles.
*/
`timescale 1ns/10ps

module jmi_pulse_sync
(
  input  wire logic src_clk_i,
  input  wire logic src_rst_i,
  input  wire logic src_pulse_i,
  input  wire logic dst_clk_i,
  input  wire logic dst_rst_i,
  output logic      dst_pulse_o
);

  logic src_tgl_ff;
  logic dst_s1_ff;
  logic dst_s2_ff;
  logic dst_s3_ff;

  always_ff @(posedge src_clk_i)
  begin
    if (src_rst_i)
      src_tgl_ff <= 1'b0;
    else if (src_pulse_i)
      src_tgl_ff <= ~src_tgl_ff;
  end

  always_ff @(posedge dst_clk_i)
  begin
    if (dst_rst_i)
    begin
      dst_s1_ff <= 1'b0;
      dst_s2_ff <= 1'b0;
      dst_s3_ff <= 1'b0;
    end
    else
    begin
      dst_s1_ff <= src_tgl_ff;
      dst_s2_ff <= dst_s1_ff;
      dst_s3_ff <= dst_s2_ff;
    end
  end

  assign dst_pulse_o = dst_s2_ff ^ dst_s3_ff;

endmodule : jmi_pulse_sync

// [hw/jmi_ctrl.sv]
/*
  Measurement scheduling, motion interrupt and control register of a
  magnetic joystick sensor, with the register port facing the serial link.
  Assumes a serial slave engine on lnk_clk_i that presents the address
  pointer, write strobes and read acknowledges, and a converter on sys_clk_i.
*/
// Behaviour
// - With the mode bit at 0, measurements start from an internal timer at the period that bits 6:4 select.
// - With the mode bit at 1, a measurement starts after the acknowledge of a read of the Y register at 11h.
// - Time-base codes 000b..111b give 20, 40, 80, 100, 140, 200, 260 and 320 ms, 111b after reset.
// - Bit 3 at 0 lets the interrupt pin drive low; at 1 the pin stays released.
// - With bit 2 at 0 the interrupt asserts after each measurement, or 450 us after a Y read in host mode.
// - The interrupt releases after the acknowledge of a Y register read.
// - With bit 2 at 1 the interrupt asserts only when the magnet leaves the dead zone of registers 12h..15h.
// - In dead-zone mode the interrupt asserts again at the next measurement if still outside the zone.
// - Writing 1 to bit 1 reloads every register, the control register to F0h, and the bit then clears.
// - Bit 0 reads 0 while a conversion runs and 1 once new X and Y are present.
// - While the pointer holds 0Fh, 10h or 11h, control, X and Y reads stay frozen.
// - After reset the control register holds F0h.
// - X and Y are signed 8-bit two's-complement values.
`timescale 1ns/10ps
`include "jmi_cfg.svh"

module jmi_ctrl
#(
  parameter int CYC_PER_MS  = `JMI_CYC_PER_MS,
  parameter int IRQ_DLY_CYC = `JMI_IRQ_DLY_CYC
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic       lnk_clk_i,
  input  wire logic [7:0] lnk_ptr_i,
  input  wire logic       lnk_wr_i,
  input  wire logic [7:0] lnk_wdata_i,
  input  wire logic       lnk_rd_ack_i,
  output logic            lnk_addr_ok_o,
  output logic [7:0]      lnk_rdata_o,
  output logic            meas_start_o,
  input  wire logic       meas_done_i,
  input  wire logic [7:0] meas_x_i,
  input  wire logic [7:0] meas_y_i,
  output logic            motion_irq_n_o,
  output logic            motion_irq_oe_o
);

  // wake-up period in cycles for a time-base code
  function automatic logic [31:0] tb_period(input logic [2:0] code);
    int ms;
    case (code)
      3'h0:    ms = `JMI_TB0_MS;
      3'h1:    ms = `JMI_TB1_MS;
      3'h2:    ms = `JMI_TB2_MS;
      3'h3:    ms = `JMI_TB3_MS;
      3'h4:    ms = `JMI_TB4_MS;
      3'h5:    ms = `JMI_TB5_MS;
      3'h6:    ms = `JMI_TB6_MS;
      default: ms = `JMI_TB7_MS;
    endcase
    return 32'(ms * CYC_PER_MS);
  endfunction : tb_period

  // dead-zone test on signed coordinates
  function automatic logic outside_zone(input logic signed [7:0] x,
                                        input logic signed [7:0] y,
                                        input logic signed [7:0] left,
                                        input logic signed [7:0] right,
                                        input logic signed [7:0] top,
                                        input logic signed [7:0] bottom);
    return (x > left) || (x < right) || (y > top) || (y < bottom);
  endfunction : outside_zone
  function automatic logic in_freeze(input logic [7:0] ptr);
    return (ptr == `JMI_OFS_CTRL) || (ptr == `JMI_OFS_X) || (ptr == `JMI_OFS_Y);
  endfunction : in_freeze
  // link domain
  logic                lrst_s1_ff, lrst_s2_ff, lnk_frz_ff, lnk_yrd;
  logic [7:0]          lnk_waddr_ff, lnk_wdata_ff, lnk_rdata_ff;
  // system domain
  jmi_pkg::jmi_state_t state_ff, nxt_state;
  logic                frz_s1_ff, frz_s2_ff, wr_pls, yrd_pls, mode_ff, irq_off_ff, zone_ff;
  logic                dly_run_ff, irq_ff, meas_start_ff, coord_ok_ff;
  logic                rst_all, tick, dly_done, start_req, soft_req, irq_set;
  logic [2:0]          tb_ff;
  logic [7:0]          left_ff, right_ff, top_ff, bottom_ff, x_ff, y_ff;
  logic [7:0]          vis_ctrl_ff, vis_x_ff, vis_y_ff, srst_cnt_ff, ctrl_now;
  logic [31:0]         tb_cnt_ff, dly_cnt_ff;
  // link-side reset is the system reset brought over by two flops
  always_ff @(posedge lnk_clk_i)
  begin
    lrst_s1_ff <= srst_i;
    lrst_s2_ff <= lrst_s1_ff;
  end

  always_ff @(posedge lnk_clk_i)
  begin
    if (lrst_s2_ff)
      lnk_frz_ff <= 1'b0;
    else
      lnk_frz_ff <= in_freeze(lnk_ptr_i);
  end

  // write hold registers, stable until the next byte
  always_ff @(posedge lnk_clk_i)
  begin
    if (lrst_s2_ff)
    begin
      lnk_waddr_ff <= 8'h00;
      lnk_wdata_ff <= 8'h00;
    end
    else if (lnk_wr_i)
    begin
      lnk_waddr_ff <= lnk_ptr_i;
      lnk_wdata_ff <= lnk_wdata_i;
    end
  end

  // read data; system-side values are static while read
  always_ff @(posedge lnk_clk_i)
  begin
    if (lrst_s2_ff)
      lnk_rdata_ff <= 8'h00;
    else
    begin
      case (lnk_ptr_i)
        `JMI_OFS_CTRL:   lnk_rdata_ff <= vis_ctrl_ff;
        `JMI_OFS_X:      lnk_rdata_ff <= vis_x_ff;
        `JMI_OFS_Y:      lnk_rdata_ff <= vis_y_ff;
        `JMI_OFS_LEFT:   lnk_rdata_ff <= left_ff;
        `JMI_OFS_RIGHT:  lnk_rdata_ff <= right_ff;
        `JMI_OFS_TOP:    lnk_rdata_ff <= top_ff;
        `JMI_OFS_BOTTOM: lnk_rdata_ff <= bottom_ff;
        default:         lnk_rdata_ff <= 8'h00;
      endcase
    end
  end
  assign lnk_rdata_o   = lnk_rdata_ff;
  assign lnk_addr_ok_o = (lnk_ptr_i >= `JMI_OFS_CTRL) && (lnk_ptr_i <= `JMI_OFS_BOTTOM);
  assign lnk_yrd       = lnk_rd_ack_i && (lnk_ptr_i == `JMI_OFS_Y);
  jmi_pulse_sync u_wr_sync
  (
    .src_clk_i (lnk_clk_i), .src_rst_i (lrst_s2_ff), .src_pulse_i (lnk_wr_i),
    .dst_clk_i (sys_clk_i), .dst_rst_i (srst_i),     .dst_pulse_o (wr_pls)
  );
  jmi_pulse_sync u_yrd_sync
  (
    .src_clk_i (lnk_clk_i), .src_rst_i (lrst_s2_ff), .src_pulse_i (lnk_yrd),
    .dst_clk_i (sys_clk_i), .dst_rst_i (srst_i),     .dst_pulse_o (yrd_pls)
  );
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      frz_s1_ff <= 1'b0;
      frz_s2_ff <= 1'b0;
    end
    else
    begin
      frz_s1_ff <= lnk_frz_ff;
      frz_s2_ff <= frz_s1_ff;
    end
  end
  // soft reset ends by reloading everything
  assign rst_all  = srst_i || ((state_ff == jmi_pkg::ST_SRST) && (srst_cnt_ff == `JMI_SRST_CYC));
  assign soft_req = wr_pls && (lnk_waddr_ff == `JMI_OFS_CTRL) && lnk_wdata_ff[`JMI_BIT_SRST];
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
    begin
      mode_ff    <= 1'((`JMI_RST_CTRL >> `JMI_BIT_MODE) & 8'h01);
      tb_ff      <= 3'(`JMI_RST_CTRL >> `JMI_BIT_TB_LO);
      irq_off_ff <= 1'((`JMI_RST_CTRL >> `JMI_BIT_IRQ_OFF) & 8'h01);
      zone_ff    <= 1'((`JMI_RST_CTRL >> `JMI_BIT_ZONE) & 8'h01);
    end
    else if (wr_pls && (lnk_waddr_ff == `JMI_OFS_CTRL) && (state_ff != jmi_pkg::ST_SRST))
    begin
      mode_ff    <= lnk_wdata_ff[`JMI_BIT_MODE];
      tb_ff      <= lnk_wdata_ff[`JMI_BIT_TB_HI:`JMI_BIT_TB_LO];
      irq_off_ff <= lnk_wdata_ff[`JMI_BIT_IRQ_OFF];
      zone_ff    <= lnk_wdata_ff[`JMI_BIT_ZONE];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
    begin
      left_ff   <= `JMI_RST_LEFT;
      right_ff  <= `JMI_RST_RIGHT;
      top_ff    <= `JMI_RST_TOP;
      bottom_ff <= `JMI_RST_BOTTOM;
    end
    else if (wr_pls)
    begin
      case (lnk_waddr_ff)
        `JMI_OFS_LEFT:   left_ff   <= lnk_wdata_ff;
        `JMI_OFS_RIGHT:  right_ff  <= lnk_wdata_ff;
        `JMI_OFS_TOP:    top_ff    <= lnk_wdata_ff;
        `JMI_OFS_BOTTOM: bottom_ff <= lnk_wdata_ff;
        default:         left_ff   <= left_ff;
      endcase
    end
  end

  // coordinates from the converter, signed as delivered
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
    begin
      x_ff <= `JMI_RST_COORD;
      y_ff <= `JMI_RST_COORD;
      coord_ok_ff <= 1'b0;
    end
    else if (meas_done_i && (state_ff == jmi_pkg::ST_MEAS))
    begin
      x_ff <= meas_x_i;
      y_ff <= meas_y_i;
      coord_ok_ff <= 1'b1;
    end
  end

  always_comb
  begin
    ctrl_now                    = 8'h00;
    ctrl_now[`JMI_BIT_MODE]     = mode_ff;
    ctrl_now[`JMI_BIT_TB_HI:`JMI_BIT_TB_LO] = tb_ff;
    ctrl_now[`JMI_BIT_IRQ_OFF]  = irq_off_ff;
    ctrl_now[`JMI_BIT_ZONE]     = zone_ff;
    ctrl_now[`JMI_BIT_SRST]     = (state_ff == jmi_pkg::ST_SRST);
    ctrl_now[`JMI_BIT_VALID]    = (state_ff == jmi_pkg::ST_RUN) && coord_ok_ff && !srst_i;
  end

  // copies seen by the link, held while the pointer sits on them
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      vis_ctrl_ff <= `JMI_RST_CTRL;
      vis_x_ff    <= `JMI_RST_COORD;
      vis_y_ff    <= `JMI_RST_COORD;
    end
    else if (!frz_s2_ff)
    begin
      vis_ctrl_ff <= ctrl_now;
      vis_x_ff    <= x_ff;
      vis_y_ff    <= y_ff;
    end
  end

  // autonomous wake-up timer
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all || mode_ff)
      tb_cnt_ff <= 32'h00000000;
    else if (tick)
      tb_cnt_ff <= 32'h00000000;
    else
      tb_cnt_ff <= tb_cnt_ff + 32'h00000001;
  end
  assign tick = !mode_ff && (tb_cnt_ff >= tb_period(tb_ff) - 32'h00000001);
  // 450 us delay after a Y read in host mode
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
    begin
      dly_run_ff <= 1'b0;
      dly_cnt_ff <= 32'h00000000;
    end
    else if (yrd_pls && mode_ff)
    begin
      dly_run_ff <= 1'b1;
      dly_cnt_ff <= 32'h00000000;
    end
    else if (dly_done)
      dly_run_ff <= 1'b0;
    else if (dly_run_ff)
      dly_cnt_ff <= dly_cnt_ff + 32'h00000001;
  end
  assign dly_done = dly_run_ff && (dly_cnt_ff == 32'(IRQ_DLY_CYC - 1));
  assign start_req = mode_ff ? yrd_pls : tick;
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      jmi_pkg::ST_RUN:
      begin
        if (soft_req)
          nxt_state = jmi_pkg::ST_SRST;
        else if (start_req)
          nxt_state = jmi_pkg::ST_MEAS;
      end
      jmi_pkg::ST_MEAS:
      begin
        if (soft_req)
          nxt_state = jmi_pkg::ST_SRST;
        else if (meas_done_i)
          nxt_state = jmi_pkg::ST_RUN;
      end
      jmi_pkg::ST_SRST:
      begin
        if (srst_cnt_ff == `JMI_SRST_CYC)
          nxt_state = jmi_pkg::ST_RUN;
      end
      default:
        nxt_state = jmi_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      state_ff <= jmi_pkg::ST_RUN;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || (state_ff != jmi_pkg::ST_SRST))
      srst_cnt_ff <= 8'h00;
    else
      srst_cnt_ff <= srst_cnt_ff + 8'h01;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      meas_start_ff <= 1'b0;
    else
      meas_start_ff <= (state_ff == jmi_pkg::ST_RUN) && !soft_req && start_req;
  end
  assign meas_start_o = meas_start_ff;
  // interrupt source; a new event wins over the clearing read
  always_comb
  begin
    irq_set = 1'b0;
    if (zone_ff)
      irq_set = meas_done_i && (state_ff == jmi_pkg::ST_MEAS) &&
                outside_zone(meas_x_i, meas_y_i, left_ff, right_ff, top_ff, bottom_ff);
    else if (mode_ff)
      irq_set = dly_done;
    else
      irq_set = meas_done_i && (state_ff == jmi_pkg::ST_MEAS);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
      irq_ff <= 1'b0;
    else if (irq_set)
      irq_ff <= 1'b1;
    else if (yrd_pls)
      irq_ff <= 1'b0;
  end
  assign motion_irq_n_o  = 1'b0;
  assign motion_irq_oe_o = irq_ff && !irq_off_ff;
endmodule : jmi_ctrl

// [dv/jmi_ctrl_chk.sv]
/* Port assertions for jmi_ctrl.
   Sees only top-level ports; bound to every jmi_ctrl below. */
`timescale 1ns/10ps
module jmi_ctrl_chk
#(
  parameter int CYC_PER_MS  = 20,
  parameter int IRQ_DLY_CYC = 30
)
(
  input wire logic       sys_clk_i,
  input wire logic       srst_i,
  input wire logic       lnk_clk_i,
  input wire logic [7:0] lnk_ptr_i,
  input wire logic       lnk_rd_ack_i,
  input wire logic       lnk_addr_ok_o,
  input wire logic [7:0] lnk_rdata_o,
  input wire logic       meas_start_o,
  input wire logic       meas_done_i,
  input wire logic       motion_irq_n_o,
  input wire logic       motion_irq_oe_o
);
  logic busy_ff;

  // conversion in flight
  always_ff @(posedge sys_clk_i)
    if (srst_i)
      busy_ff <= 1'b0;
    else if (meas_start_o)
      busy_ff <= 1'b1;
    else if (meas_done_i)
      busy_ff <= 1'b0;

  a_pin_drives_low: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    motion_irq_n_o == 1'b0) else $error("pin level");
  a_start_one_cycle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    meas_start_o |=> !meas_start_o) else $error("start too long");
  a_start_when_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    meas_start_o |-> !busy_ff) else $error("start while busy");
  a_reset_quiet: assert property (@(posedge sys_clk_i)
    srst_i |=> !meas_start_o && !motion_irq_oe_o) else $error("active in reset");
  a_addr_ok_map: assert property (@(posedge lnk_clk_i) disable iff (srst_i)
    lnk_addr_ok_o == (lnk_ptr_i >= 8'h0F && lnk_ptr_i <= 8'h15)) else $error("decode");
  a_unmapped_zero: assert property (@(posedge lnk_clk_i) disable iff (srst_i)
    !lnk_addr_ok_o |=> lnk_rdata_o == 8'h00) else $error("unmapped read");
  a_y_read_frozen: assert property (@(posedge lnk_clk_i) disable iff (srst_i)
    (lnk_ptr_i == 8'h11) [*4] |=> $stable(lnk_rdata_o)) else $error("frozen read moved");
  a_irq_clear_y: assert property (@(posedge lnk_clk_i) disable iff (srst_i)
    lnk_rd_ack_i && lnk_ptr_i == 8'h11 |=> !motion_irq_oe_o) else $error("irq not cleared");

  c_start: cover property (@(posedge sys_clk_i) meas_start_o);
  c_irq_set: cover property (@(posedge sys_clk_i) $rose(motion_irq_oe_o));
  c_y_ack: cover property (@(posedge lnk_clk_i) lnk_rd_ack_i && lnk_ptr_i == 8'h11);
endmodule : jmi_ctrl_chk

bind jmi_ctrl jmi_ctrl_chk #(.CYC_PER_MS(CYC_PER_MS), .IRQ_DLY_CYC(IRQ_DLY_CYC)) u_chk
(
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .lnk_clk_i(lnk_clk_i), .lnk_ptr_i(lnk_ptr_i),
  .lnk_rd_ack_i(lnk_rd_ack_i), .lnk_addr_ok_o(lnk_addr_ok_o), .lnk_rdata_o(lnk_rdata_o),
  .meas_start_o(meas_start_o), .meas_done_i(meas_done_i), .motion_irq_n_o(motion_irq_n_o),
  .motion_irq_oe_o(motion_irq_oe_o)
);

// [dv/jmi_conv_model.sv]
/* Converter stand-in: answers each start after DLY cycles.
   Assumes the bench sets the coordinates it returns. */
`timescale 1ns/10ps
module jmi_conv_model
#(
  parameter int DLY = 200
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [7:0] x_set_i,
  input  wire logic [7:0] y_set_i,
  output logic            done_o,
  output logic [7:0]      x_o,
  output logic [7:0]      y_o
);
  int cnt_ff;

  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i)
      cnt_ff <= 0;
    else if (start_i)
      cnt_ff <= DLY;
    else if (cnt_ff == 1)
    begin
      cnt_ff <= 0;
      done_o <= 1'b1;
    end
    else if (cnt_ff > 1)
      cnt_ff <= cnt_ff - 1;
  end

  // coordinates hold only with done
  always_comb x_o = done_o ? x_set_i : ~x_set_i;
  always_comb y_o = done_o ? y_set_i : ~y_set_i;
endmodule : jmi_conv_model

// [dv/jmi_ctrl_bench.sv]
/* Self-checking bench for jmi_ctrl.
   Converter model on the measurement port; link driven by tasks. */
`timescale 1ns/10ps
module jmi_ctrl_bench;
  localparam int CPM = 20;
  logic        sys_clk;
  logic        lnk_clk;
  logic        srst;
  logic  [7:0] ptr;
  logic        wr;
  logic  [7:0] wdata;
  logic        ack;
  logic  [7:0] rdata;
  logic        start;
  logic        done;
  logic  [7:0] mx;
  logic  [7:0] my;
  logic  [7:0] cx;
  logic  [7:0] cy;
  logic        irq_oe;
  logic        irq_n;
  logic        irq_pin;
  logic [15:0] v;
  int          n_mismatch;
  int          num_checks;
  int          n;
  int          n_start;
  int          s0;
  int          per_ms[8] = '{20, 40, 80, 100, 140, 200, 260, 320};
  logic  [7:0] tx[4] = '{8'h06, 8'hFA, 8'h00, 8'h00};
  logic  [7:0] ty[4] = '{8'h00, 8'h00, 8'h06, 8'hFA};

  jmi_ctrl #(.CYC_PER_MS(CPM), .IRQ_DLY_CYC(30)) u_dut
  (
    .sys_clk_i(sys_clk), .srst_i(srst), .lnk_clk_i(lnk_clk), .lnk_ptr_i(ptr), .lnk_wr_i(wr),
    .lnk_wdata_i(wdata), .lnk_rd_ack_i(ack), .lnk_addr_ok_o(), .lnk_rdata_o(rdata),
    .meas_start_o(start), .meas_done_i(done), .meas_x_i(cx), .meas_y_i(cy),
    .motion_irq_n_o(irq_n), .motion_irq_oe_o(irq_oe)
  );
  // pull-up on the released interrupt line
  assign irq_pin = irq_oe ? irq_n : 1'b1;
  jmi_conv_model u_conv
  (
    .clk_i(sys_clk), .rst_i(srst), .start_i(start), .x_set_i(mx), .y_set_i(my),
    .done_o(done), .x_o(cx), .y_o(cy)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    lnk_clk = 1'b0;
    #3;
    forever #62.5 lnk_clk = ~lnk_clk;
  end
  always @(posedge sys_clk)
    if (start === 1'b1)
      n_start++;

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(input int s);
    return s == 0 ? start : (s == 1 ? irq_oe : done);
  endfunction : pick

  // bounded wait for start, interrupt or done
  task automatic wait_sys(input int s, input int lim);
    n = 0;
    while (pick(s) !== 1'b1 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (pick(s) !== 1'b1)
    begin
      n_mismatch++;
      $display("wrong value at %0t: wait ran out", $time);
      conclude();
    end
  endtask : wait_sys

  // pointer off the frozen range, writes kept apart
  task automatic park();
    ptr = 8'h20;
    repeat (3) @(negedge lnk_clk);
  endtask : park

  task automatic lnk_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge lnk_clk);
    ptr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge lnk_clk);
    wr = 1'b0;
    park();
  endtask : lnk_wr

  task automatic lnk_rd(input logic [7:0] a, input logic k);
    @(negedge lnk_clk);
    ptr = a;
    @(negedge lnk_clk);
    v = {8'h00, rdata};
    ack = k;
    @(negedge lnk_clk);
    ack = 1'b0;
  endtask : lnk_rd

  initial
  begin
    srst = 1'b1;
    ptr = 8'h20;
    wr = 1'b0;
    wdata = 8'h00;
    ack = 1'b0;
    mx = 8'h80;
    my = 8'h7F;
    repeat (8) @(negedge lnk_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge lnk_clk);
    lnk_rd(8'h0F, 1'b0);
    check(v, 16'h00F0);
    lnk_rd(8'h13, 1'b0);
    check(v, 16'h00FB);
    s0 = n_start;
    lnk_rd(8'h11, 1'b1);
    park();
    lnk_rd(8'h0F, 1'b0);
    check(v, 16'h00F0);
    check(16'(n_start), 16'(s0 + 1));
    wait_sys(1, 60);
    wait_sys(2, 250);
    park();
    lnk_rd(8'h0F, 1'b0);
    check(v, 16'h00F1);
    lnk_rd(8'h10, 1'b0);
    check(v, 16'h0080);
    lnk_rd(8'h11, 1'b0);
    check(v, 16'h007F);
    my = 8'h33;
    lnk_rd(8'h11, 1'b1);
    repeat (260) @(negedge sys_clk);
    lnk_rd(8'h11, 1'b0);
    check(v, 16'h007F);
    park();
    lnk_rd(8'h11, 1'b0);
    check(v, 16'h0033);
    lnk_wr(8'h0F, 8'hF8);
    lnk_rd(8'h11, 1'b1);
    repeat (300) @(negedge sys_clk);
    check({15'h0000, irq_oe}, 16'h0000);
    check({15'h0000, irq_pin}, 16'h0001);
    lnk_wr(8'h12, 8'h10);
    lnk_rd(8'h12, 1'b0);
    check(v, 16'h0010);
    lnk_wr(8'h0F, 8'hFA);
    lnk_rd(8'h0F, 1'b0);
    check(v, 16'h00F0);
    lnk_rd(8'h12, 1'b0);
    check(v, 16'h0005);
    for (int c = 0; c < 8; c++)
    begin
      lnk_wr(8'h0F, {1'b0, 3'(c), 4'h0});
      wait_sys(0, 7000);
      @(negedge sys_clk);
      wait_sys(0, 7000);
      check(16'(n + 1), 16'(per_ms[c] * CPM));
    end
    check({15'h0000, irq_oe}, 16'h0001);
    check({15'h0000, irq_pin}, 16'h0000);
    mx = 8'h05;
    my = 8'hFB;
    lnk_wr(8'h0F, 8'h04);
    wait_sys(2, 900);
    lnk_rd(8'h11, 1'b1);
    repeat (900) @(negedge sys_clk);
    check({15'h0000, irq_oe}, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      mx = tx[k];
      my = ty[k];
      wait_sys(2, 900);
      lnk_rd(8'h11, 1'b1);
      repeat (4) @(negedge sys_clk);
      check({15'h0000, irq_oe}, 16'h0000);
      wait_sys(1, 900);
    end
    conclude();
  end
endmodule : jmi_ctrl_bench
